//--- csp_port.sv
// chip select port pin mux with axi4-lite register slave
`timescale 1ns/100ps
`default_nettype none
module csp_port (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // axi4-lite write address and data
    input wire logic [csp_pkg::CSP_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [csp_pkg::CSP_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // system state
    input wire logic [2:0] op_mode,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire logic out_port_enable,
    input wire logic [2:0] dram_type_field,
    // bus controller strobes, active low
    input wire logic chip_select_zero_n,
    input wire logic chip_select_one_n,
    input wire logic chip_select_two_n,
    input wire logic chip_select_three_n,
    input wire logic col_strobe_n,
    // pins
    input wire logic [4:0] pin_in,
    output logic [4:0] pin_out,
    output logic [4:0] pin_oe
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic regs_rst; // chip reset or hardware standby
    logic [4:0] dir_reg; // pin_direction, only bits 4..0 exist
    logic [4:0] latch_reg; // output_latch
    logic [4:0] level_reg; // pin_level snapshot
    csp_pkg::csp_fctl_s fctl_reg; // port_function_control_two
    logic [4:0] pin_sync; // filtered pin levels
    logic aw_full_reg; // write address captured
    logic w_full_reg; // write data captured
    logic [csp_pkg::CSP_AW-1:0] awaddr_reg;
    logic [7:0] wbyte_reg; // only byte lane 0 carries data
    logic wlane_reg; // lane 0 strobe of captured data
    logic do_write; // both halves present, perform write
    csp_pkg::csp_sel_e wsel; // register hit by the write
    csp_pkg::csp_sel_e rsel; // register hit by the read
    logic single_chip; // mode 7, all pins general purpose
    logic dram_on; // pin zero carries the column strobe
    logic [4:0] bus_fn; // pin currently owned by the bus controller
    logic [4:0] bus_sig; // bus controller strobe per pin
    csp_pkg::csp_drive_s drive_next;

    assign regs_rst = sys_rst | hw_standby;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // aligned word decode; the two low address bits select nothing
    function automatic csp_pkg::csp_sel_e decode(input logic [csp_pkg::CSP_AW-1:0] a);
        logic [15:0] idx;
        idx = a[csp_pkg::CSP_AW-1:2];
        case (idx)
            csp_pkg::CSP_IDX_DIR: decode = csp_pkg::CSP_SEL_DIR;
            csp_pkg::CSP_IDX_LATCH: decode = csp_pkg::CSP_SEL_LATCH;
            csp_pkg::CSP_IDX_LEVEL: decode = csp_pkg::CSP_SEL_LEVEL;
            csp_pkg::CSP_IDX_FCTL: decode = csp_pkg::CSP_SEL_FCTL;
            default: decode = csp_pkg::CSP_SEL_NONE;
        endcase
    endfunction : decode

    assign wsel = decode(awaddr_reg);
    assign rsel = decode(s_axi_araddr);
    assign do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid;

    // ------------------------------------------------------------
    // axi write channels
    // ------------------------------------------------------------
    // address and data are taken in either order and held until used
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            aw_full_reg <= 1'b0;
            s_axi_awready <= 1'b1;
            awaddr_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            s_axi_awready <= 1'b0;
            awaddr_reg <= s_axi_awaddr;
        end else if (do_write) begin
            aw_full_reg <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1; // one write at a time
        end
    end

    // data half of the write
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            w_full_reg <= 1'b0;
            s_axi_wready <= 1'b1;
            wbyte_reg <= 8'h00;
            wlane_reg <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            s_axi_wready <= 1'b0;
            wbyte_reg <= s_axi_wdata[7:0];
            wlane_reg <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_full_reg <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    // write response, slverr for an unmapped word
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= csp_pkg::CSP_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            if (wsel == csp_pkg::CSP_SEL_NONE) begin
                s_axi_bresp <= csp_pkg::CSP_RESP_SLVERR;
            end else begin
                s_axi_bresp <= csp_pkg::CSP_RESP_OKAY;
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // direction: mode decides pin four at reset; kept in software standby, reset again in hardware standby
    always_ff @(posedge clock) begin
        if (regs_rst) begin
            if (op_mode == csp_pkg::CSP_MODE_FOUR || op_mode == csp_pkg::CSP_MODE_FIVE) begin
                dir_reg <= csp_pkg::CSP_DIR_RST_BUS;
            end else begin
                dir_reg <= csp_pkg::CSP_DIR_RST_LOW;
            end
        end else if (do_write && wlane_reg && !sw_standby && wsel == csp_pkg::CSP_SEL_DIR) begin
            dir_reg <= wbyte_reg[4:0]; // bits 7..5 dropped
        end
    end

    // output latch; reserved upper bits never stored
    always_ff @(posedge clock) begin
        if (regs_rst) begin
            latch_reg <= csp_pkg::CSP_LATCH_RST;
        end else if (do_write && wlane_reg && !sw_standby
                     && wsel == csp_pkg::CSP_SEL_LATCH) begin
            latch_reg <= wbyte_reg[4:0];
        end
    end

    // function control; low three bits are read-only zero
    always_ff @(posedge clock) begin
        if (regs_rst) begin
            fctl_reg <= csp_pkg::csp_fctl_s'(csp_pkg::CSP_FCTL_RST);
        end else if (do_write && wlane_reg && !sw_standby
                     && wsel == csp_pkg::CSP_SEL_FCTL) begin
            fctl_reg <= csp_pkg::csp_fctl_s'({wbyte_reg[7:3], 3'h0});
        end
    end

    // pin level snapshot: latch where output, filtered pin where input;
    // frozen in software standby, loads the filtered pin in hardware standby; a write to it has no path at all
    always_ff @(posedge clock) begin
        if (regs_rst) begin
            level_reg <= pin_sync;
        end else if (!sw_standby) begin
            level_reg <= (dir_reg & latch_reg) | (~dir_reg & pin_sync);
        end
    end

    // ------------------------------------------------------------
    // axi read channel
    // ------------------------------------------------------------
    // answer one cycle after the address is taken
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= csp_pkg::CSP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= csp_pkg::CSP_RESP_OKAY;
            case (rsel)
                // write-only register: its undefined read is zero here
                csp_pkg::CSP_SEL_DIR: s_axi_rdata <= 32'h0000_0000;
                csp_pkg::CSP_SEL_LATCH: s_axi_rdata <= {27'h000_0000, latch_reg};
                csp_pkg::CSP_SEL_LEVEL: s_axi_rdata <= {27'h000_0000, level_reg};
                csp_pkg::CSP_SEL_FCTL: s_axi_rdata <= {24'h00_0000, fctl_reg};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= csp_pkg::CSP_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // pin function
    // ------------------------------------------------------------
    csp_sync3 #(
        .W(csp_pkg::CSP_PORT_W)
    ) u_pin_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in(pin_in),
        .clean_out(pin_sync)
    );

    assign single_chip = (op_mode == csp_pkg::CSP_MODE_SINGLE);
    // dram none or types 100..111 leave pin zero to the port
    assign dram_on = (dram_type_field != csp_pkg::CSP_DRAM_NONE)
                     && !dram_type_field[csp_pkg::CSP_DRAM_HI_BIT];

    // ownership of each pin; the enable bits are assumed changed only
    // while directions are clear, else a select may glitch out
    always_comb begin
        bus_fn = 5'h00;
        bus_fn[csp_pkg::CSP_PIN_CS0] = !single_chip && dir_reg[4];
        bus_fn[csp_pkg::CSP_PIN_CS1] = !single_chip && dir_reg[3]
            && fctl_reg.select_one_six_seven_enable;
        bus_fn[csp_pkg::CSP_PIN_CS2] = !single_chip && dir_reg[2]
            && fctl_reg.select_two_to_five_enable;
        bus_fn[csp_pkg::CSP_PIN_CS3] = !single_chip && dir_reg[1]
            && fctl_reg.select_two_to_five_enable;
        bus_fn[csp_pkg::CSP_PIN_CAS] = !single_chip && dram_on;
    end

    assign bus_sig = {chip_select_zero_n, chip_select_one_n, chip_select_two_n,
                      chip_select_three_n, col_strobe_n};

    // drive per pin: bus strobe, latch, or float
    always_comb begin
        drive_next.level = 5'h00;
        drive_next.enable = 5'h00;
        for (int i = 0; i < csp_pkg::CSP_PORT_W; i++) begin
            if (hw_standby) begin
                drive_next.level[i] = 1'b0; // all pins float
                drive_next.enable[i] = 1'b0;
            end else if (bus_fn[i] && sw_standby) begin
                // bus pins idle high or float, chosen by the enable bit
                drive_next.level[i] = csp_pkg::CSP_PIN_IDLE[i];
                drive_next.enable[i] = out_port_enable;
            end else if (bus_fn[i]) begin
                drive_next.level[i] = bus_sig[i];
                drive_next.enable[i] = 1'b1;
            end else begin
                // general i/o; in standby outputs keep driving, inputs float
                drive_next.level[i] = latch_reg[i];
                drive_next.enable[i] = dir_reg[i];
            end
        end
    end

    // pins leave through flip-flops; one cycle behind the strobes
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pin_out <= 5'h00;
            pin_oe <= 5'h00;
        end else begin
            pin_out <= drive_next.level;
            pin_oe <= drive_next.enable;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_dir_reset: assert property (@(posedge clock) regs_rst |=>
        dir_reg == ((($past(op_mode) == csp_pkg::CSP_MODE_FOUR)
        || ($past(op_mode) == csp_pkg::CSP_MODE_FIVE)) ? 5'h10 : 5'h00))
        else $error("direction reset value wrong");
    chk_latch_reset: assert property (@(posedge clock) regs_rst |=> latch_reg == 5'h00)
        else $error("latch not cleared");
    chk_fctl_reset: assert property (@(posedge clock) regs_rst |=> fctl_reg == 8'h30)
        else $error("function control reset wrong");
    chk_dir_kept: assert property (@(posedge clock) disable iff (regs_rst)
        sw_standby |=> $stable(dir_reg) && $stable(latch_reg))
        else $error("registers changed in standby");
    chk_level_frozen: assert property (@(posedge clock) disable iff (regs_rst)
        sw_standby |=> $stable(level_reg))
        else $error("pin level moved in standby");
    chk_level_mux: assert property (@(posedge clock) disable iff (regs_rst)
        !sw_standby |=> level_reg == (($past(dir_reg) & $past(latch_reg))
        | (~$past(dir_reg) & $past(pin_sync))))
        else $error("pin level mux wrong");
    chk_cs0_route: assert property (@(posedge clock) disable iff (sys_rst)
        (!hw_standby && !sw_standby && !single_chip && dir_reg[4])
        |=> pin_oe[4] && pin_out[4] == $past(chip_select_zero_n))
        else $error("chip select zero not routed");
    chk_single_gpio: assert property (@(posedge clock) disable iff (sys_rst)
        (!hw_standby && single_chip) |=> pin_oe == $past(dir_reg)
        && pin_out == $past(latch_reg))
        else $error("mode 7 pins not general i/o");
    chk_cas_route: assert property (@(posedge clock) disable iff (sys_rst)
        (!hw_standby && !sw_standby && !single_chip && dram_on)
        |=> pin_oe[0] && pin_out[0] == $past(col_strobe_n))
        else $error("column strobe not routed");
    chk_standby_bus: assert property (@(posedge clock) disable iff (sys_rst)
        (sw_standby && !hw_standby && bus_fn[3]) |=> pin_out[3]
        && pin_oe[3] == $past(out_port_enable))
        else $error("standby bus pin drive wrong");
    chk_read_answer: assert property (@(posedge clock) disable iff (sys_rst)
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid && s_axi_rresp
        == (($past(rsel) == csp_pkg::CSP_SEL_NONE) ? 2'h2 : 2'h0))
        else $error("read answer wrong");
    cov_fctl_write: cover property (@(posedge clock) do_write
        && wsel == csp_pkg::CSP_SEL_FCTL);
    cov_cs1_drive: cover property (@(posedge clock) bus_fn[3] && !sw_standby);
    cov_standby_float: cover property (@(posedge clock) sw_standby
        && !out_port_enable && bus_fn[4]);
endmodule : csp_port
`default_nettype wire

//--- csp_pkg.sv
// constants, types and register map of the chip select port pin mux
`default_nettype none
package csp_pkg;
    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [15:0] CSP_IDX_DIR = 16'hFEBF; // pin_direction, write only
    localparam logic [15:0] CSP_IDX_LATCH = 16'hFF6F; // output_latch, read/write
    localparam logic [15:0] CSP_IDX_LEVEL = 16'hFF5F; // pin_level, read only
    localparam logic [15:0] CSP_IDX_FCTL = 16'hFFAC; // port_function_control_two
    localparam int CSP_AW = 18; // byte address width seen by the slave
    localparam int CSP_PORT_W = 5; // pins on the port
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [4:0] CSP_DIR_RST_BUS = 5'h10; // modes 4 and 5
    localparam logic [4:0] CSP_DIR_RST_LOW = 5'h00; // modes 6 and 7
    localparam logic [4:0] CSP_LATCH_RST = 5'h00;
    localparam logic [7:0] CSP_FCTL_RST = 8'h30;
    localparam logic [4:0] CSP_PIN_IDLE = 5'h1F; // chip selects idle high
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CSP_PIN_CS0 = 4; // pin carrying chip_select_zero
    localparam int CSP_PIN_CS1 = 3; // pin carrying chip_select_one
    localparam int CSP_PIN_CS2 = 2; // pin carrying chip_select_two
    localparam int CSP_PIN_CS3 = 1; // pin carrying chip_select_three
    localparam int CSP_PIN_CAS = 0; // pin carrying the dram column strobe
    localparam int CSP_DRAM_HI_BIT = 2; // types 100 to 111 have this bit set
    // ------------------------------------------------------------
    // operating modes and dram types
    // ------------------------------------------------------------
    localparam logic [2:0] CSP_MODE_FOUR = 3'h4;
    localparam logic [2:0] CSP_MODE_FIVE = 3'h5;
    localparam logic [2:0] CSP_MODE_SINGLE = 3'h7; // mode 7, no external bus
    localparam logic [2:0] CSP_DRAM_NONE = 3'h0;
    // ------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] CSP_RESP_OKAY = 2'h0;
    localparam logic [1:0] CSP_RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    // layout of port_function_control_two, bit 7 first
    typedef struct packed {
        logic wait_pin_choice;
        logic bus_request_out_pin_choice;
        logic select_one_six_seven_enable;
        logic select_two_to_five_enable;
        logic address_strobe_off;
        logic [2:0] reserved;
    } csp_fctl_s;
    // drive of the five pins
    typedef struct packed {
        logic [4:0] level;
        logic [4:0] enable;
    } csp_drive_s;
    // register selected by an address
    typedef enum logic [2:0] {
        CSP_SEL_DIR,
        CSP_SEL_LATCH,
        CSP_SEL_LEVEL,
        CSP_SEL_FCTL,
        CSP_SEL_NONE
    } csp_sel_e;
endpackage : csp_pkg
`default_nettype wire

//--- csp_sync3.sv
// three stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module csp_sync3 #(
    parameter int W = 5
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // asynchronous input and its clean copy
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] clean_out
);
    logic [W-1:0] s1_reg; // metastable stage, read only by s2_reg
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    // shift chain; the first stage feeds nothing but the second
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a bit changes only once two settled stages agree
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            clean_out <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    clean_out[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule : csp_sync3
`default_nettype wire

//--- csp_pin_partner.sv
// far-side model of the port pins: memory selects and other pin drivers
`timescale 1ns/100ps
`default_nettype none
module csp_pin_partner (
    // drive from the port
    input wire logic [4:0] pin_out,
    input wire logic [4:0] pin_oe,
    // level the far side puts on pins the port leaves free
    input wire logic [4:0] ext_level,
    // resolved wire level
    output logic [4:0] pin_in
);
    // a driven pin shows the port's level, a free pin the far side's
    assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule : csp_pin_partner
`default_nettype wire

//--- csp_port_tb_top.sv
// self-checking bench for the chip select port pin mux
`timescale 1ns/100ps
`default_nettype none
module csp_port_tb_top;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clock = 1'b0, sys_rst = 1'b1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, hw_standby = 0, sw_standby = 0;
    logic out_port_enable = 0, chip_select_zero_n = 1, chip_select_one_n = 1;
    logic chip_select_two_n = 1, chip_select_three_n = 1, col_strobe_n = 1;
    logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic [2:0] op_mode = 3'h4, dram_type_field = 3'h0;
    logic [4:0] ext_level = 5'h00;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [4:0] pin_in, pin_out, pin_oe;
    int failures = 0, n_compared = 0;
    localparam logic [15:0] DIR = csp_pkg::CSP_IDX_DIR, LAT = csp_pkg::CSP_IDX_LATCH;
    localparam logic [15:0] LEV = csp_pkg::CSP_IDX_LEVEL, FCT = csp_pkg::CSP_IDX_FCTL;
    localparam logic [1:0] OK = csp_pkg::CSP_RESP_OKAY, ERR = csp_pkg::CSP_RESP_SLVERR;
    // clock of 4 ns
    always #2 clock = ~clock;
    csp_port u_csp_port (.clock, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .op_mode, .hw_standby, .sw_standby,
        .out_port_enable, .dram_type_field, .chip_select_zero_n, .chip_select_one_n,
        .chip_select_two_n, .chip_select_three_n, .col_strobe_n, .pin_in, .pin_out, .pin_oe);
    csp_pin_partner u_csp_pin_partner (.pin_out, .pin_oe, .ext_level, .pin_in);
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [34:0] got, input logic [34:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
        int n;
        @(posedge clock);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        s_axi_bready <= 1'b0;
        // bvalid is part of the compare, so a timed-out wait fails here
        chk({32'h0000_0000, s_axi_bvalid, s_axi_bresp}, {32'h0000_0000, 1'b1, er});
    endtask : wr
    task automatic rd(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
        int n;
        @(posedge clock);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        s_axi_rready <= 1'b0;
        chk({s_axi_rvalid, s_axi_rresp, s_axi_rdata}, {1'b1, er, 24'h00_0000, d});
    endtask : rd
    // only driven pins have a defined level, so undriven ones are masked
    task automatic pins(input logic [4:0] o, input logic [4:0] e);
        repeat (3) @(posedge clock);
        chk({25'h000_0000, pin_oe, pin_out & pin_oe}, {25'h000_0000, e, o & e});
    endtask : pins
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        rd(FCT, 8'h30, OK);
        rd(LAT, 8'h00, OK);
        rd(DIR, 8'h00, OK);
        chip_select_zero_n <= 1'b0;
        pins(5'h00, 5'h10);
        $display("test reset done");
        wr(DIR, 8'hFF, OK);
        wr(LAT, 8'hFF, OK);
        rd(LAT, 8'h1F, OK);
        rd(LEV, 8'h1F, OK);
        chip_select_two_n <= 1'b0;
        pins(5'h0B, 5'h1F);
        dram_type_field <= 3'h1;
        col_strobe_n <= 1'b0;
        pins(5'h0A, 5'h1F);
        dram_type_field <= 3'h4;
        pins(5'h0B, 5'h1F);
        $display("test bus pins done");
        // enables are changed only with all directions cleared;
        // select one stays on, selects two and three go off
        wr(DIR, 8'h00, OK);
        wr(FCT, 8'h20, OK);
        wr(LAT, 8'h15, OK);
        wr(DIR, 8'h1F, OK);
        pins(5'h0D, 5'h1F);
        wr(LEV, 8'h00, OK);
        wr(16'h0000, 8'h00, ERR);
        rd(16'h0000, 8'h00, ERR);
        rd(LAT, 8'h15, OK);
        $display("test general outputs done");
        sw_standby <= 1'b1;
        wr(LAT, 8'h00, OK);
        pins(5'h05, 5'h07);
        out_port_enable <= 1'b1;
        pins(5'h1D, 5'h1F);
        sw_standby <= 1'b0;
        rd(LAT, 8'h15, OK);
        $display("test standby done");
        wr(DIR, 8'h00, OK);
        ext_level <= 5'h0A;
        repeat (8) @(posedge clock);
        rd(LEV, 8'h0A, OK);
        op_mode <= 3'h7;
        wr(DIR, 8'h1F, OK);
        pins(5'h15, 5'h1F);
        wr(FCT, 8'hFF, OK);
        rd(FCT, 8'hF8, OK);
        hw_standby <= 1'b1;
        @(posedge clock);
        hw_standby <= 1'b0;
        rd(FCT, 8'h30, OK);
        rd(LAT, 8'h00, OK);
        pins(5'h00, 5'h00);
        // hardware standby in mode 5 sets pin four's direction, in mode 6 not
        op_mode <= 3'h5;
        hw_standby <= 1'b1;
        @(posedge clock);
        hw_standby <= 1'b0;
        pins(5'h00, 5'h10);
        op_mode <= 3'h6;
        hw_standby <= 1'b1;
        @(posedge clock);
        hw_standby <= 1'b0;
        pins(5'h00, 5'h00);
        $display("test mode seven done");
        report_and_stop();
    end
    // watchdog well beyond the hundred and thirty or so cycles the tests need
    initial begin
        #80000;
        failures++;
        report_and_stop();
    end
endmodule : csp_port_tb_top
`default_nettype wire
